// ===== hw/cfg_ctrl_pkg.sv
// Constants, field layout and carrier types for the configuration control block
//
// Summary of operation
// - Pin-select lock bit 13 set blocks pin-select register writes; clear lets them through.
// - Module-disable lock bit 12 set blocks module-disable register writes; clear allows.
// - Bit 3 set enables the debug test port; clear disables it.
// - Bit 0 set makes two-wire debug use test data output; clear leaves it unused.
// - Lock bits change only after a completed unlock sequence; otherwise refused.
// - Bits 31-14 and 11-4 read zero; bits 2-1 read one.
package cfg_ctrl_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_CTRL_OFFSET = 12'h000;
    localparam logic [11:0] UNLOCK_KEY_OFFSET = 12'h004;
    localparam logic [11:0] PIN_SEL_OFFSET = 12'h010;
    localparam logic [11:0] MOD_DIS_OFFSET = 12'h020;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PIN_SELECT_LOCK_BIT = 13;
    localparam int MODULE_DISABLE_LOCK_BIT = 12;
    localparam int DEBUG_PORT_ENABLE_BIT = 3;
    localparam int TWO_WIRE_DATA_OUT_USE_BIT = 0;

    // ------------------------------------------------------------
    // Fixed read pattern and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_FIXED_ONES = 32'h0000_0006;
    localparam logic [31:0] CFG_WRITABLE_MASK = 32'h0000_3009;
    localparam logic CFG_LOCK_RESET = 1'b0;
    localparam logic CFG_DEBUG_RESET = 1'b1;
    localparam logic CFG_TWO_WIRE_RESET = 1'b1;
    localparam logic [31:0] PIN_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] MOD_DIS_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Unlock sequence keys
    // ------------------------------------------------------------
    localparam logic [31:0] UNLOCK_KEY_FIRST = 32'haa99_6655;
    localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h5566_99aa;

    // Configuration fields as held by the register
    typedef struct packed {
        logic pin_select_lock;
        logic module_disable_lock;
        logic debug_port_enable;
        logic two_wire_data_out_use;
    } cfg_fields_s;

    // One accepted APB write
    typedef struct packed {
        logic valid;
        logic [11:0] addr;
        logic [31:0] data;
    } bus_write_s;

endpackage

// ===== hw/unlock_seq.sv
// Two-key unlock sequence detector for lock-bit changes
`timescale 1ns/1ps
`default_nettype none
module unlock_seq
    import cfg_ctrl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire bus_write_s wr_i,
    input wire logic consume_i,
    output logic unlocked_o
);

    typedef enum logic [2:0] {
        ST_LOCKED = 3'b001,
        ST_HALF = 3'b010,
        ST_OPEN = 3'b100
    } unlock_state_e;

    unlock_state_e state_q;
    unlock_state_e state_d;
    logic key_wr;

    assign key_wr = wr_i.valid && (wr_i.addr == UNLOCK_KEY_OFFSET);

    // Next state: two keys back to back open; any other key write relocks.
    // A first key always restarts the sequence, so software that repeats the
    // whole sequence while already open, or after a stray first key, still opens.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_LOCKED: begin
                if (key_wr && wr_i.data == UNLOCK_KEY_FIRST) begin
                    state_d = ST_HALF;
                end
            end
            ST_HALF: begin
                if (key_wr && wr_i.data == UNLOCK_KEY_SECOND) begin
                    state_d = ST_OPEN;
                end else if (key_wr && wr_i.data != UNLOCK_KEY_FIRST) begin
                    state_d = ST_LOCKED;
                end
            end
            ST_OPEN: begin
                if (key_wr && wr_i.data == UNLOCK_KEY_FIRST) begin
                    state_d = ST_HALF;
                end else if (consume_i || key_wr) begin
                    state_d = ST_LOCKED;
                end
            end
            default: begin
                state_d = ST_LOCKED;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_q <= ST_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    assign unlocked_o = (state_q == ST_OPEN);

endmodule
`default_nettype wire

// ===== hw/guarded_reg.sv
// A 32-bit register whose writes are refused while its lock is set
`timescale 1ns/1ps
`default_nettype none
module guarded_reg
    import cfg_ctrl_pkg::*;
#(
    parameter logic [11:0] ADDR = 12'h000,
    parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire bus_write_s wr_i,
    input wire logic lock_i,
    output logic [31:0] value_o
);

    logic [31:0] value_q;
    logic [31:0] value_d;

    // Store only when addressed and unlocked
    always_comb begin
        value_d = value_q;
        if (wr_i.valid && wr_i.addr == ADDR && !lock_i) begin
            value_d = wr_i.data;
        end
    end

    // Value register
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            value_q <= RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end

    assign value_o = value_q;

endmodule
`default_nettype wire

// ===== hw/cfg_ctrl.sv
// Configuration control register bank with APB slave and lock logic
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl
    import cfg_ctrl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic debug_port_enable_o,
    output logic two_wire_data_out_use_o,
    output logic [31:0] pin_select_o,
    output logic [31:0] module_disable_o
);

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    bus_write_s wr;
    logic access;
    logic mapped;
    logic [31:0] strb_mask;
    logic unlocked;
    logic lock_change;
    cfg_fields_s cfg_q;
    cfg_fields_s cfg_d;
    logic [31:0] cfg_word;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    // Expand byte strobes to a bit mask
    function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // Zero-wait slave: every access completes in its first access cycle
    assign access = psel_i && penable_i;
    assign pready_o = 1'b1;
    assign mapped = (paddr_i == CFG_CTRL_OFFSET) || (paddr_i == UNLOCK_KEY_OFFSET) ||
                    (paddr_i == PIN_SEL_OFFSET) || (paddr_i == MOD_DIS_OFFSET);
    assign pslverr_o = access && !mapped;
    assign strb_mask = strobe_mask(pstrb_i);

    // Write carrier; partial strobes keep untouched bytes of the target
    always_comb begin
        wr.valid = access && pwrite_i && mapped;
        wr.addr = paddr_i;
        case (paddr_i)
            CFG_CTRL_OFFSET: wr.data = (pwdata_i & strb_mask) | (cfg_word & ~strb_mask);
            PIN_SEL_OFFSET: wr.data = (pwdata_i & strb_mask) | (pin_select_o & ~strb_mask);
            MOD_DIS_OFFSET: wr.data = (pwdata_i & strb_mask) | (module_disable_o & ~strb_mask);
            default: wr.data = pwdata_i;
        endcase
    end

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    unlock_seq u_unlock (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .wr_i(wr),
        .consume_i(lock_change),
        .unlocked_o(unlocked)
    );

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        lock_change = 1'b0;
        if (wr.valid && wr.addr == CFG_CTRL_OFFSET) begin
            cfg_d.debug_port_enable = wr.data[DEBUG_PORT_ENABLE_BIT];
            cfg_d.two_wire_data_out_use = wr.data[TWO_WIRE_DATA_OUT_USE_BIT];
            if ((wr.data[PIN_SELECT_LOCK_BIT] != cfg_q.pin_select_lock) ||
                (wr.data[MODULE_DISABLE_LOCK_BIT] != cfg_q.module_disable_lock)) begin
                if (unlocked) begin
                    cfg_d.pin_select_lock = wr.data[PIN_SELECT_LOCK_BIT];
                    cfg_d.module_disable_lock = wr.data[MODULE_DISABLE_LOCK_BIT];
                    lock_change = 1'b1;
                end
            end
        end
    end

    // Configuration state
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            cfg_q.pin_select_lock <= CFG_LOCK_RESET;
            cfg_q.module_disable_lock <= CFG_LOCK_RESET;
            cfg_q.debug_port_enable <= CFG_DEBUG_RESET;
            cfg_q.two_wire_data_out_use <= CFG_TWO_WIRE_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Read image: fixed ones and zeros, stored bits in place
    always_comb begin
        cfg_word = CFG_FIXED_ONES;
        cfg_word[PIN_SELECT_LOCK_BIT] = cfg_q.pin_select_lock;
        cfg_word[MODULE_DISABLE_LOCK_BIT] = cfg_q.module_disable_lock;
        cfg_word[DEBUG_PORT_ENABLE_BIT] = cfg_q.debug_port_enable;
        cfg_word[TWO_WIRE_DATA_OUT_USE_BIT] = cfg_q.two_wire_data_out_use;
    end

    assign debug_port_enable_o = cfg_q.debug_port_enable;
    assign two_wire_data_out_use_o = cfg_q.two_wire_data_out_use;

    // ------------------------------------------------------------
    // Lock-guarded register groups
    // ------------------------------------------------------------
    guarded_reg #(
        .ADDR(PIN_SEL_OFFSET),
        .RESET_VALUE(PIN_SEL_RESET)
    ) u_pin_sel (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .wr_i(wr),
        .lock_i(cfg_q.pin_select_lock),
        .value_o(pin_select_o)
    );

    guarded_reg #(
        .ADDR(MOD_DIS_OFFSET),
        .RESET_VALUE(MOD_DIS_RESET)
    ) u_mod_dis (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .wr_i(wr),
        .lock_i(cfg_q.module_disable_lock),
        .value_o(module_disable_o)
    );

    // ------------------------------------------------------------
    // Read data, registered during setup so it is ready in access
    // ------------------------------------------------------------
    always_comb begin
        case (paddr_i)
            CFG_CTRL_OFFSET: rdata_d = cfg_word;
            PIN_SEL_OFFSET: rdata_d = pin_select_o;
            MOD_DIS_OFFSET: rdata_d = module_disable_o;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_o = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pin_sel_locked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cfg_q.pin_select_lock |=> $stable(pin_select_o))
        else $error("pin select changed while locked");

    a_mod_dis_locked: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        cfg_q.module_disable_lock |=> $stable(module_disable_o))
        else $error("module disable changed while locked");

    a_pin_sel_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr.valid && wr.addr == PIN_SEL_OFFSET && !cfg_q.pin_select_lock)
        |=> pin_select_o == $past(wr.data))
        else $error("unlocked pin select write lost");

    a_mod_dis_open: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr.valid && wr.addr == MOD_DIS_OFFSET && !cfg_q.module_disable_lock)
        |=> module_disable_o == $past(wr.data))
        else $error("unlocked module disable write lost");

    a_debug_follows: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr.valid && wr.addr == CFG_CTRL_OFFSET)
        |=> debug_port_enable_o == $past(wr.data[DEBUG_PORT_ENABLE_BIT]))
        else $error("debug enable did not follow write");

    a_two_wire_follows: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr.valid && wr.addr == CFG_CTRL_OFFSET)
        |=> two_wire_data_out_use_o == $past(wr.data[TWO_WIRE_DATA_OUT_USE_BIT]))
        else $error("two-wire data use did not follow write");

    a_lock_needs_key: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !unlocked |=> $stable(cfg_q.pin_select_lock) && $stable(cfg_q.module_disable_lock))
        else $error("lock bit changed without unlock");

    a_fixed_bits: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (psel_i && !penable_i && paddr_i == CFG_CTRL_OFFSET)
        |=> (prdata_o & ~CFG_WRITABLE_MASK) == CFG_FIXED_ONES)
        else $error("unimplemented bits read wrong");

    // Guarded words move only on a write addressed to them
    a_pin_sel_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !(wr.valid && wr.addr == PIN_SEL_OFFSET) |=> $stable(pin_select_o))
        else $error("pin select changed without a write");

    a_mod_dis_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !(wr.valid && wr.addr == MOD_DIS_OFFSET) |=> $stable(module_disable_o))
        else $error("module disable changed without a write");

    // Debug controls move only on a configuration write
    a_debug_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !(wr.valid && wr.addr == CFG_CTRL_OFFSET) |=> $stable(debug_port_enable_o))
        else $error("debug enable changed without a write");

    a_two_wire_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !(wr.valid && wr.addr == CFG_CTRL_OFFSET) |=> $stable(two_wire_data_out_use_o))
        else $error("two-wire data use changed without a write");

    // An open unlock lets a configuration write set both locks as written
    a_lock_taken: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (wr.valid && wr.addr == CFG_CTRL_OFFSET && unlocked)
        |=> cfg_q.pin_select_lock == $past(wr.data[PIN_SELECT_LOCK_BIT]) &&
            cfg_q.module_disable_lock == $past(wr.data[MODULE_DISABLE_LOCK_BIT]))
        else $error("unlocked lock write lost");

    // One lock change uses up the unlock, so a second change needs new keys
    a_lock_consumed: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        lock_change |=> !unlocked)
        else $error("unlock not used up by lock change");

    // Read data captured at setup carries the value that stood at that edge
    a_pin_sel_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (psel_i && !penable_i && paddr_i == PIN_SEL_OFFSET)
        |=> prdata_o == $past(pin_select_o))
        else $error("pin select read back wrong");

    a_mod_dis_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (psel_i && !penable_i && paddr_i == MOD_DIS_OFFSET)
        |=> prdata_o == $past(module_disable_o))
        else $error("module disable read back wrong");

    a_cfg_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (psel_i && !penable_i && paddr_i == CFG_CTRL_OFFSET)
        |=> prdata_o[DEBUG_PORT_ENABLE_BIT] == $past(debug_port_enable_o) &&
            prdata_o[TWO_WIRE_DATA_OUT_USE_BIT] == $past(two_wire_data_out_use_o))
        else $error("debug controls read back wrong");

    a_lock_read: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (psel_i && !penable_i && paddr_i == CFG_CTRL_OFFSET)
        |=> prdata_o[PIN_SELECT_LOCK_BIT] == $past(cfg_q.pin_select_lock) &&
            prdata_o[MODULE_DISABLE_LOCK_BIT] == $past(cfg_q.module_disable_lock))
        else $error("lock bits read back wrong");

endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the configuration control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cfg_ctrl_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, dbg_o, tw_o;
    logic [31:0] pin_o, mod_o;
    int error_cnt = 0;
    int comparisons = 0;
    // Bench copy of the register state
    logic [1:0] lk;
    logic dbg, tw, unl, k1;
    logic [31:0] pin_m, mod_m;

    cfg_ctrl cfg_ctrl_inst (
        .clk_sys_i(clk_sys),
        .nrst_i(nrst),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .pstrb_i(pstrb),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .debug_port_enable_o(dbg_o),
        .two_wire_data_out_use_o(tw_o),
        .pin_select_o(pin_o),
        .module_disable_o(mod_o)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and closing
    // ------------------------------------------------------------
    always #4 clk_sys = ~clk_sys;

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        results();
    end

    task automatic results();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Byte-strobe merge: unselected bytes keep their old contents
    function automatic logic [31:0] merge(logic [31:0] n, logic [31:0] o);
        logic [31:0] m;
        m = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        return (n & m) | (o & ~m);
    endfunction

    // Bench copy back to its reset values
    task automatic model_reset();
        lk = {2{CFG_LOCK_RESET}};
        dbg = CFG_DEBUG_RESET;
        tw = CFG_TWO_WIRE_RESET;
        unl = 1'b0;
        k1 = 1'b0;
        pin_m = PIN_SEL_RESET;
        mod_m = MOD_DIS_RESET;
    endtask

    // Expected readback of the configuration word
    function automatic logic [31:0] cfg_word(logic [1:0] l, logic d, logic t);
        return {18'h0, l, 8'h0, d, 2'b11, t};
    endfunction

    // ------------------------------------------------------------
    // APB master: hold the request until pready is seen high
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        logic done;
        done = 1'b0;
        rd = '0;
        err = 1'b0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (pready === 1'b1) begin
                done = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write through the bus and advance the bench copy
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd, e;
        logic err, mapped;
        apb(1'b1, a, d, rd, err);
        mapped = 1'b1;
        case (a)
            CFG_CTRL_OFFSET: begin
                e = merge(d, cfg_word(lk, dbg, tw));
                if (unl && e[13:12] !== lk) begin
                    lk = e[13:12];
                    unl = 1'b0;
                end
                dbg = e[3];
                tw = e[0];
            end
            UNLOCK_KEY_OFFSET: begin
                unl = k1 && (d === UNLOCK_KEY_SECOND);
                k1 = (d === UNLOCK_KEY_FIRST);
            end
            PIN_SEL_OFFSET: if (!lk[1]) pin_m = merge(d, pin_m);
            MOD_DIS_OFFSET: if (!lk[0]) mod_m = merge(d, mod_m);
            default: mapped = 1'b0;
        endcase
        chk({31'h0, err}, {31'h0, !mapped});
    endtask

    task automatic unlock();
        wr(UNLOCK_KEY_OFFSET, UNLOCK_KEY_FIRST);
        wr(UNLOCK_KEY_OFFSET, UNLOCK_KEY_SECOND);
    endtask

    // Read back all three words and compare every register and control output with the bench copy
    task automatic check_all();
        logic [31:0] rd;
        logic err;
        apb(1'b0, CFG_CTRL_OFFSET, 32'h0, rd, err);
        chk(rd, cfg_word(lk, dbg, tw));
        apb(1'b0, PIN_SEL_OFFSET, 32'h0, rd, err);
        chk(rd, pin_m);
        apb(1'b0, MOD_DIS_OFFSET, 32'h0, rd, err);
        chk(rd, mod_m);
        chk({31'h0, dbg_o}, {31'h0, dbg});
        chk({31'h0, tw_o}, {31'h0, tw});
        chk(pin_o, pin_m);
        chk(mod_o, mod_m);
    endtask

    // ------------------------------------------------------------
    // Main sequence: corner cases, then random traffic
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd, d;
        logic err;
        int op;
        model_reset();
        void'($urandom(32'hb3c8));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        check_all();
        // All ones without unlock: locks and fixed bits must not move
        wr(CFG_CTRL_OFFSET, 32'hffff_ffff);
        check_all();
        wr(CFG_CTRL_OFFSET, 32'h0000_0000);
        check_all();
        // Wrong second key leaves the locks closed
        wr(UNLOCK_KEY_OFFSET, UNLOCK_KEY_FIRST);
        wr(UNLOCK_KEY_OFFSET, 32'h0000_0000);
        wr(CFG_CTRL_OFFSET, 32'h0000_3009);
        check_all();
        // Pin-select lock set, then writes to both guarded words
        unlock();
        wr(CFG_CTRL_OFFSET, 32'h0000_2000);
        wr(PIN_SEL_OFFSET, $urandom);
        wr(MOD_DIS_OFFSET, $urandom);
        check_all();
        // Unlock already used up: this change is refused
        wr(CFG_CTRL_OFFSET, 32'h0000_3000);
        check_all();
        // Swap to module-disable lock only
        unlock();
        wr(CFG_CTRL_OFFSET, 32'h0000_1009);
        wr(PIN_SEL_OFFSET, $urandom);
        wr(MOD_DIS_OFFSET, $urandom);
        check_all();
        // Unmapped place: error, reads zero, nothing changes
        apb(1'b0, 12'h100, 32'h0, rd, err);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(12'h100, 32'hffff_ffff);
        check_all();
        unlock();
        wr(CFG_CTRL_OFFSET, 32'h0000_0000);
        check_all();
        // Random mix of writes, with and without unlock
        repeat (60) begin
            pstrb <= ($urandom % 2) ? 4'hf : 4'($urandom);
            op = $urandom % 4;
            d = $urandom;
            case (op)
                0: wr(CFG_CTRL_OFFSET, d);
                1: wr(PIN_SEL_OFFSET, d);
                2: wr(MOD_DIS_OFFSET, d);
                default: begin
                    unlock();
                    wr(CFG_CTRL_OFFSET, d);
                end
            endcase
            check_all();
        end
        // Reset in mid-run: registers and the unlock state return to defaults
        pstrb <= 4'hf;
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        model_reset();
        check_all();
        wr(CFG_CTRL_OFFSET, 32'h0000_3009);
        check_all();
        results();
    end
endmodule
`default_nettype wire
